// file: verilog/rhi_pkg.sv
// reader host interface: shared constants, word layout, op codes
// assumes a 20 MHz system clock on both ends of the link
`default_nettype none
package rhi_pkg;
  // ----------------------------------------
  // register map of the device
  // ----------------------------------------
  localparam int         NUM_REGS        = 32;
  localparam int         QUEUE_DEPTH     = 24;
  localparam logic [4:0] ADDR_DEEP_FIRST = 5'h12;
  localparam logic [4:0] ADDR_DEEP_LAST  = 5'h17;
  localparam logic [4:0] ADDR_NO_CARRY   = 5'h13;
  localparam logic [4:0] ADDR_TX_LEN_LO  = 5'h1D;
  localparam logic [4:0] ADDR_TX_LEN_HI  = 5'h1E;
  localparam logic [4:0] ADDR_QUEUE      = 5'h1F;
  localparam logic [4:0] CMD_QUEUE_CLEAR = 5'h0F;
  localparam logic [1:0] LANE_LAST       = 2'd2;
  // ----------------------------------------
  // address / command word fields
  // ----------------------------------------
  localparam int WB_CMD   = 7;
  localparam int WB_READ  = 6;
  localparam int WB_BURST = 5;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int         CLK_NS      = 50;
  localparam int         STEP_NS     = 300;
  localparam int         STEP_CYC    = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STEP_LAST   = 4'(STEP_CYC - 1);
  localparam logic [2:0] HOLD_CYC    = 3'd4;
  // ----------------------------------------
  // host controller registers and ops
  // ----------------------------------------
  localparam logic [2:0] HREG_CTRL   = 3'h0;
  localparam logic [2:0] HREG_OP     = 3'h1;
  localparam logic [2:0] HREG_DATA   = 3'h2;
  localparam logic [2:0] HREG_STATUS = 3'h3;
  localparam logic [2:0] HREG_RX     = 3'h4;
  localparam logic [7:0] SER_OE      = 8'h92;
  localparam logic [7:0] SER_IDLE    = 8'h12;
  localparam logic [7:0] SEL_BIT     = 8'h10;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CMD   = 2'b01,
    ST_SGL   = 2'b10,
    ST_BURST = 2'b11
  } rhi_state_type;

  typedef enum logic [2:0] {
    OP_ENABLE     = 3'b000,
    OP_START      = 3'b001,
    OP_STOP_SGL   = 3'b010,
    OP_STOP_BURST = 3'b011,
    OP_WRITE      = 3'b100,
    OP_READ       = 3'b101
  } rhi_op_type;

  function automatic logic is_deep(input logic [4:0] a);
    is_deep = (a >= ADDR_DEEP_FIRST) && (a <= ADDR_DEEP_LAST);
  endfunction
endpackage
`default_nettype wire

// file: verilog/rhi_if.sv
// reader host interface: link between host controller and reader device
// undriven lines read low; each party drives only bits whose enable is high
`default_nettype none
interface rhi_if;
  logic       link_clk;
  logic       chip_en;
  logic [7:0] host_o;
  logic [7:0] host_oe;
  logic [7:0] dev_o;
  logic [7:0] dev_oe;
  wire  [7:0] line;

  assign line = (host_o & host_oe) | (dev_o & dev_oe);

  modport host (
    output link_clk,
    output chip_en,
    output host_o,
    output host_oe,
    input  line
  );
  modport dev (
    input  link_clk,
    input  chip_en,
    input  line,
    output dev_o,
    output dev_oe
  );
endinterface
`default_nettype wire

// file: verilog/rhi_device.sv
// reader host interface: device end (slave), register file and data queue
// assumes link pins come from another domain; all are double synchronised
//
// Function
// RL1: after single or command, any access follows
// RL2: burst ends only by burst stop
// RL3: byte registers reachable single or burst
// RL4: deep registers 12,14..17 burst only; code treats all of 12..17 as deep, 13 included
// RL5: deep bytes low, middle, high order
// RL6: byte position tracked per deep register
// RL7: no carry from 13 into 14
// RL8: queue at 1F reached by burst only
// RL9: clear, transmit, length, payload in one stream
// RL10: line seven rise, clock high: start
// RL11: line seven fall, clock high: single stop
// RL12: rise then fall, clock low: burst stop
// RL13: single stop also ends direct operation
// RL14: parallel read drives only while clock high
// RL15: serial pins: select, clock, in, out
// RL16: select high holds serial part in reset
// RL17: serial input sampled on clock fall
// RL18: output updated on rise, host samples fall
// RL19: eight bit words, most significant first
// RL20: bit7 command, bit6 read, bit5 burst
// RL21: burst address increments per data byte
// RL22: single address takes exactly one byte
// RL23: enable rise latches parallel or serial
// RL24: start or stop clears word assembly
`default_nettype none
module rhi_device
  import rhi_pkg::*;
#(
  parameter int QDEPTH = QUEUE_DEPTH
)(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_queue_pop,
  rhi_if.dev               lnk,
  output logic             o_serial_mode,
  output logic             o_active,
  output logic             o_cmd_stb,
  output logic [4:0]       o_cmd_code,
  output logic             o_direct_end,
  output logic [15:0]      o_tx_length,
  output logic [4:0]       o_queue_level,
  output logic [7:0]       o_queue_head
);
  localparam int QPW = $clog2(QDEPTH);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [9:0]    sync1_r;
  logic [9:0]    sync2_r;
  logic [9:0]    prev_r;
  logic          active_r;
  logic          serial_r;
  logic          rose_low_r;
  logic          drive_r;
  logic [2:0]    hold_r;
  logic [7:0]    out_r;
  logic          miso_r;
  logic [2:0]    bit_cnt_r;
  logic [6:0]    shift_r;
  rhi_state_type state_r;
  logic [4:0]    addr_r;
  logic          rd_r;
  logic [1:0]    lane_r;
  logic          halt_r;
  logic          cmd_stb_r;
  logic [4:0]    cmd_code_r;
  logic          direct_end_r;
  logic [23:0]   reg_mem [NUM_REGS];
  logic [7:0]    q_mem [QDEPTH];
  logic [QPW-1:0] q_wp_r;
  logic [QPW-1:0] q_rp_r;
  logic [4:0]    q_cnt_r;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end
    else
    begin
      sync1_r <= {lnk.chip_en, lnk.link_clk, lnk.line};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ----------------------------------------
  // condition detection
  // ----------------------------------------
  wire s_en    = sync2_r[9];
  wire en_p    = prev_r[9];
  wire ck      = sync2_r[8];
  wire ck_p    = prev_r[8];
  wire d7      = sync2_r[7];
  wire d7_p    = prev_r[7];
  wire sel     = ~sync2_r[4];
  wire sel_p   = ~prev_r[4];
  wire par_on  = active_r & ~serial_r;
  wire ser_on  = active_r & serial_r;
  // own read data must not look like a start or stop
  wire quiet   = ~drive_r & (hold_r == 3'd0);
  wire d7_rise = quiet & d7 & ~d7_p;
  wire d7_fall = quiet & ~d7 & d7_p;
  // RL10: start on rise while high
  wire p_start = par_on & d7_rise & ck & ck_p;
  // RL11: single stop on fall while high
  wire p_stop_sgl = par_on & d7_fall & ck & ck_p;
  // RL12: fall after rise in one low phase
  wire p_stop_burst = par_on & d7_fall & ~ck & ~ck_p & rose_low_r;
  wire p_word  = par_on & ck & ~ck_p & (state_r != ST_IDLE);
  // RL16: select edges open and close
  wire s_start = ser_on & sel & ~sel_p;
  wire s_stop  = ser_on & ~sel & sel_p;
  // RL17: sample on serial clock fall
  wire s_fall  = ser_on & sel & ~ck & ck_p;
  wire s_rise  = ser_on & sel & ck & ~ck_p;
  // RL19: word complete after eight bits
  wire s_word  = s_fall & (bit_cnt_r == 3'd7) & (state_r != ST_IDLE);
  wire dis     = active_r & ~s_en;
  wire burst   = state_r == ST_BURST;
  // RL2: single stop does not close a burst
  wire stop_ok = burst ? p_stop_burst : p_stop_sgl;
  wire start   = p_start | s_start;
  wire stop    = stop_ok | s_stop | dis;
  wire word_stb = p_word | s_word;
  wire [7:0] word_in = serial_r ? {shift_r, d7} : sync2_r[7:0];

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  wire in_data  = (state_r == ST_SGL) | burst;
  wire at_queue = addr_r == ADDR_QUEUE;
  wire deep     = is_deep(addr_r);
  // RL3: byte registers in either mode
  // RL4: deep registers refused in single mode
  // RL8: queue refused in single mode
  wire legal    = in_data & ~halt_r & (burst | (~deep & ~at_queue));
  wire acc      = word_stb & legal;
  wire wr_reg   = acc & ~rd_r & ~at_queue;
  wire q_full   = q_cnt_r == 5'(QDEPTH);
  wire q_empty  = q_cnt_r == 5'd0;
  wire q_push   = acc & ~rd_r & at_queue & ~q_full;
  wire q_pop_h  = acc & rd_r & at_queue & ~q_empty;
  wire q_pop    = q_pop_h | (i_queue_pop & ~q_empty);
  // RL20: bit 7 marks a command
  wire cmd      = word_stb & (state_r == ST_CMD) & word_in[WB_CMD];
  // RL9: queue clear inside a setup stream
  wire q_clear  = cmd & (word_in[4:0] == CMD_QUEUE_CLEAR);
  wire [23:0] rd_word = reg_mem[addr_r];
  // RL5: lane index picks low, middle, high
  wire [7:0] rd_reg = rd_word[{lane_r, 3'b000} +: 8];
  wire [7:0] rd_byte = ~legal ? 8'h00 : at_queue ? q_mem[q_rp_r] : rd_reg;
  wire last_lane = ~deep | (lane_r == LANE_LAST);

  function automatic logic [QPW-1:0] next_ptr(input logic [QPW-1:0] p);
    next_ptr = (p == QPW'(QDEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ----------------------------------------
  // mode latch and stream state
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      active_r <= 1'b0;
      serial_r <= 1'b0;
    end
    else if (s_en & ~en_p)
    begin
      // RL23: all lines low selects parallel
      active_r <= 1'b1;
      serial_r <= |sync2_r[7:0];
    end
    else if (~s_en)
    begin
      active_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_r <= ST_IDLE;
      addr_r  <= '0;
      rd_r    <= 1'b0;
      lane_r  <= '0;
      halt_r  <= 1'b0;
    end
    else if (start | stop)
    begin
      // RL24: conditions drop partial words
      state_r <= start ? ST_CMD : ST_IDLE;
      addr_r  <= '0;
      rd_r    <= 1'b0;
      lane_r  <= '0;
      halt_r  <= 1'b0;
    end
    else if (word_stb)
    begin
      unique case (state_r)
        ST_IDLE: state_r <= ST_IDLE;
        ST_CMD:
        begin
          if (!word_in[WB_CMD])
          begin
            // RL20: read and burst flags
            addr_r  <= word_in[4:0];
            rd_r    <= word_in[WB_READ];
            lane_r  <= '0;
            state_r <= word_in[WB_BURST] ? ST_BURST : ST_SGL;
          end
        end
        // RL22: one byte, then a new word
        // RL1: any access type may follow
        ST_SGL: state_r <= ST_CMD;
        ST_BURST:
        begin
          if (!halt_r)
          begin
            // RL6: byte position of deep register
            if (!last_lane)
              lane_r <= lane_r + 2'd1;
            else
            begin
              lane_r <= '0;
              // RL7: stop at 13, queue repeats
              if (addr_r == ADDR_NO_CARRY)
                halt_r <= 1'b1;
              // RL21: next address per byte
              else if (!at_queue)
                addr_r <= addr_r + 5'd1;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // serial word assembly and output bit
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      bit_cnt_r <= '0;
      shift_r   <= '0;
      miso_r    <= 1'b0;
    end
    else if (start | stop)
    begin
      bit_cnt_r <= '0;
      shift_r   <= '0;
      miso_r    <= 1'b0;
    end
    else
    begin
      if (s_fall)
      begin
        shift_r   <= {shift_r[5:0], d7};
        bit_cnt_r <= bit_cnt_r + 3'd1;
      end
      // RL18: new output bit on rise
      if (s_rise)
        miso_r <= rd_byte[3'd7 - bit_cnt_r];
    end
  end

  // ----------------------------------------
  // parallel read drive
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      drive_r    <= 1'b0;
      hold_r     <= '0;
      out_r      <= '0;
      rose_low_r <= 1'b0;
    end
    else
    begin
      rose_low_r <= ck ? 1'b0 : (rose_low_r | (par_on & d7_rise & ~ck_p));
      hold_r     <= drive_r ? HOLD_CYC : (hold_r != 3'd0) ? hold_r - 3'd1 : 3'd0;
      // RL14: drive ends as clock falls
      if (p_word & in_data & rd_r)
      begin
        drive_r <= 1'b1;
        out_r   <= rd_byte;
      end
      else if (~ck | ~par_on)
        drive_r <= 1'b0;
    end
  end

  // RL15: serial output on line six only
  assign lnk.dev_oe = (ser_on & sel) ? 8'h40 : {8{drive_r & par_on}};
  assign lnk.dev_o  = serial_r ? {1'b0, miso_r, 6'b00_0000} : out_r;

  // ----------------------------------------
  // registers and data queue
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        reg_mem[i] <= '0;
      for (int j = 0; j < QDEPTH; j++)
        q_mem[j] <= '0;
      q_wp_r  <= '0;
      q_rp_r  <= '0;
      q_cnt_r <= '0;
    end
    else
    begin
      if (wr_reg)
        reg_mem[addr_r][{lane_r, 3'b000} +: 8] <= word_in;
      if (q_push)
        q_mem[q_wp_r] <= word_in;
      if (q_clear)
      begin
        q_wp_r  <= '0;
        q_rp_r  <= '0;
        q_cnt_r <= '0;
      end
      else
      begin
        if (q_push)
          q_wp_r <= next_ptr(q_wp_r);
        if (q_pop)
          q_rp_r <= next_ptr(q_rp_r);
        q_cnt_r <= q_cnt_r + {4'd0, q_push} - {4'd0, q_pop};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cmd_stb_r    <= 1'b0;
      cmd_code_r   <= '0;
      direct_end_r <= 1'b0;
    end
    else
    begin
      cmd_stb_r <= cmd;
      if (cmd)
        cmd_code_r <= word_in[4:0];
      // RL13: single stop ends direct operation
      direct_end_r <= p_stop_sgl;
    end
  end

  assign o_serial_mode = serial_r;
  assign o_active      = active_r;
  assign o_cmd_stb     = cmd_stb_r;
  assign o_cmd_code    = cmd_code_r;
  assign o_direct_end  = direct_end_r;
  assign o_tx_length   = {reg_mem[ADDR_TX_LEN_HI][7:0], reg_mem[ADDR_TX_LEN_LO][7:0]};
  assign o_queue_level = q_cnt_r;
  assign o_queue_head  = q_mem[q_rp_r];
endmodule
`default_nettype wire

// file: verilog/rhi_host.sv
// reader host interface: host end (master), sequences link conditions and words
// assumes software polls the busy bit before issuing the next op
`default_nettype none
module rhi_host
  import rhi_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  rhi_if.host             lnk,
  output logic [7:0]      o_rdata
);
  logic       mode_r;
  logic [7:0] data_r;
  rhi_op_type op_r;
  logic       busy_r;
  logic [3:0] tick_r;
  logic [1:0] sub_r;
  logic [2:0] bit_r;
  logic [7:0] rx_r;
  logic [7:0] rdata_r;
  logic       lclk_r;
  logic       len_r;
  logic [7:0] ld_r;
  logic [7:0] loe_r;
  logic [7:0] hs1_r;
  logic [7:0] hs2_r;
  logic       w_clk;
  logic       w_en;
  logic [7:0] w_d;
  logic [7:0] w_oe;
  logic [1:0] w_sub_max;
  logic       w_bits;
  logic       w_sample;

  // ----------------------------------------
  // per step pin pattern
  // ----------------------------------------
  // in parallel mode, step 0 of every op but enable only lowers the clock so data never moves with a clock edge
  always_comb
  begin
    w_en      = 1'b1;
    w_clk     = 1'b0;
    w_d       = ld_r;
    w_oe      = (sub_r == 2'd0) ? loe_r : 8'hFF;
    w_sub_max = 2'd3;
    w_bits    = 1'b0;
    w_sample  = 1'b0;
    if (mode_r)
    begin
      w_oe = SER_OE;
      unique case (op_r)
        OP_ENABLE:
        begin
          w_en      = sub_r != 2'd0;
          w_d       = SER_IDLE;
          w_sub_max = 2'd2;
        end
        // RL16: select low opens, high closes
        OP_START:
        begin
          w_d       = ld_r & ~SEL_BIT;
          w_sub_max = 2'd0;
        end
        OP_STOP_SGL,
        OP_STOP_BURST:
        begin
          w_d       = ld_r | SEL_BIT;
          w_sub_max = 2'd0;
        end
        OP_WRITE,
        OP_READ:
        begin
          // RL19: most significant bit first
          if (sub_r == 2'd0)
            w_d = {(op_r == OP_WRITE) & data_r[3'd7 - bit_r], ld_r[6:0]};
          w_clk     = sub_r == 2'd1;
          w_sub_max = 2'd2;
          w_bits    = 1'b1;
          // RL18: sampled after the clock has fallen
          // the new bit reaches the sync pair too late to take it with clock high
          w_sample  = (op_r == OP_READ) & (sub_r == 2'd2);
        end
        default: w_sub_max = 2'd0;
      endcase
    end
    else
    begin
      unique case (op_r)
        OP_ENABLE:
        begin
          w_en      = sub_r != 2'd0;
          w_d       = 8'h00;
          w_oe      = 8'hFF;
          w_sub_max = 2'd2;
        end
        OP_START:
        begin
          w_clk = sub_r[1];
          if (sub_r != 2'd0)
            w_d = (sub_r == 2'd3) ? 8'h80 : 8'h00;
        end
        OP_STOP_SGL:
        begin
          w_clk = sub_r[1];
          if (sub_r != 2'd0)
            w_d = (sub_r == 2'd3) ? 8'h00 : 8'h80;
        end
        OP_STOP_BURST:
        begin
          if (sub_r != 2'd0)
            w_d = (sub_r == 2'd2) ? 8'h80 : 8'h00;
        end
        OP_WRITE:
        begin
          w_clk = sub_r[1];
          if (sub_r != 2'd0)
            w_d = data_r;
        end
        OP_READ:
        begin
          w_clk    = sub_r[1];
          w_oe     = (sub_r == 2'd0) ? loe_r : 8'h00;
          w_sample = sub_r == 2'd3;
        end
        default: w_sub_max = 2'd0;
      endcase
    end
  end

  // ----------------------------------------
  // sequencer and software port
  // ----------------------------------------
  wire op_go = i_wr & (i_addr == HREG_OP) & ~busy_r;
  wire step_end = tick_r == 4'd0;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      hs1_r <= '0;
      hs2_r <= '0;
    end
    else
    begin
      hs1_r <= lnk.line;
      hs2_r <= hs1_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      busy_r <= 1'b0;
      op_r   <= OP_ENABLE;
      tick_r <= '0;
      sub_r  <= '0;
      bit_r  <= '0;
      rx_r   <= '0;
      lclk_r <= 1'b0;
      len_r  <= 1'b0;
      ld_r   <= '0;
      loe_r  <= '0;
    end
    else if (busy_r)
    begin
      lclk_r <= w_clk;
      len_r  <= w_en;
      ld_r   <= w_d;
      loe_r  <= w_oe;
      tick_r <= step_end ? STEP_LAST : tick_r - 4'd1;
      if (step_end)
      begin
        if (w_sample)
          rx_r <= mode_r ? {rx_r[6:0], hs2_r[6]} : hs2_r;
        if (sub_r != w_sub_max)
          sub_r <= sub_r + 2'd1;
        else
        begin
          sub_r <= '0;
          bit_r <= bit_r + 3'd1;
          if (!w_bits || bit_r == 3'd7)
          begin
            bit_r  <= '0;
            busy_r <= 1'b0;
          end
        end
      end
    end
    else if (op_go)
    begin
      op_r   <= rhi_op_type'(i_wdata[2:0]);
      busy_r <= 1'b1;
      tick_r <= STEP_LAST;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mode_r  <= 1'b0;
      data_r  <= '0;
      rdata_r <= '0;
    end
    else
    begin
      if (i_wr && i_addr == HREG_CTRL && !busy_r)
        mode_r <= i_wdata[0];
      if (i_wr && i_addr == HREG_DATA && !busy_r)
        data_r <= i_wdata;
      if (i_rd)
        rdata_r <= (i_addr == HREG_STATUS) ? {6'd0, mode_r, busy_r}
                 : (i_addr == HREG_RX) ? rx_r
                 : (i_addr == HREG_DATA) ? data_r
                 : (i_addr == HREG_CTRL) ? {7'd0, mode_r} : 8'h00;
    end
  end

  assign lnk.link_clk = lclk_r;
  assign lnk.chip_en  = len_r;
  assign lnk.host_o   = ld_r;
  assign lnk.host_oe  = loe_r;
  assign o_rdata      = rdata_r;
endmodule
`default_nettype wire

// file: testbench/rhi_props.sv
// checker for the reader host link, watches the interface wires only
// assumes instantiation beside the link, sampled by the system clock
`default_nettype none
module rhi_props
  import rhi_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       link_clk,
  input  wire logic       chip_en,
  input  wire logic [7:0] host_o,
  input  wire logic [7:0] host_oe,
  input  wire logic [7:0] dev_o,
  input  wire logic [7:0] dev_oe,
  input  wire logic [7:0] line
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ----
  // link properties
  // ----
  a_no_contention: assert property ((host_oe & dev_oe) == 8'h00)
    else $error("two drivers on one line");
  a_par_drive_high: assert property ($rose(dev_oe == 8'hFF) |-> link_clk)
    else $error("device drives bus while clock low");
  a_par_release: assert property
    ($fell(link_clk) && dev_oe == 8'hFF |-> ##[1:5] dev_oe == 8'h00)
    else $error("device holds bus after clock fall");
  a_ser_out_pin: assert property (dev_oe inside {8'h00, 8'h40, 8'hFF})
    else $error("device drives a wrong line");
  a_ser_reset: assert property
    ((line[4] && host_oe == SER_OE) [*6] |-> dev_oe == 8'h00)
    else $error("serial output active while deselected");
  a_ser_update_rise: assert property
    (dev_oe == 8'h40 && $past(dev_oe) == 8'h40 && $changed(dev_o[6]) |-> link_clk)
    else $error("serial output changed with clock low");
  a_mosi_fall: assert property
    (host_oe == SER_OE && $fell(link_clk) |-> $stable(host_o[7]))
    else $error("serial input moved at clock fall");
  a_cond_clk_high: assert property
    (link_clk && host_oe == 8'hFF && $past(host_oe) == 8'hFF && $changed(host_o)
     |-> (host_o ^ $past(host_o)) == 8'h80)
    else $error("data moved other than line seven with clock high");
  a_enable_lines: assert property ($rose(chip_en) |->
    (host_oe == 8'hFF && host_o == 8'h00) || (host_oe == SER_OE && host_o == SER_IDLE))
    else $error("enable rose with undefined mode lines");
endmodule
`default_nettype wire

// file: testbench/reader_host_interface_tb_top.sv
// bench: host end and device end joined by the link, both modes
// assumes package, interface and both ends are compiled first
`default_nettype none
module reader_host_interface_tb_top
  import rhi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk;
  logic        i_rst_b;
  logic [2:0]  i_addr;
  logic [7:0]  i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic        i_queue_pop;
  logic [7:0]  o_rdata;
  logic        o_serial_mode;
  logic        o_active;
  logic        o_cmd_stb;
  int          cmd_count;
  logic        o_direct_end;
  logic [4:0]  o_cmd_code;
  logic [15:0] o_tx_length;
  logic [4:0]  o_queue_level;
  logic [7:0]  o_queue_head;
  int          failures;
  int          check_count;
  int          stop_count;
  rhi_if lnk();
  rhi_host rhi_host_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .lnk(lnk.host), .o_rdata(o_rdata));
  rhi_device rhi_device_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_queue_pop(i_queue_pop),
    .lnk(lnk.dev), .o_serial_mode(o_serial_mode), .o_active(o_active), .o_cmd_stb(o_cmd_stb),
    .o_cmd_code(o_cmd_code), .o_direct_end(o_direct_end), .o_tx_length(o_tx_length),
    .o_queue_level(o_queue_level), .o_queue_head(o_queue_head));
  rhi_props rhi_props_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .link_clk(lnk.link_clk),
    .chip_en(lnk.chip_en), .host_o(lnk.host_o), .host_oe(lnk.host_oe),
    .dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe), .line(lnk.line));
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    if (o_direct_end === 1'b1)
      stop_count++;
    if (o_cmd_stb === 1'b1)
      cmd_count++;
  end
  // ----
  // helpers
  // ----
  function automatic logic [7:0] deep_exp(input int k, input logic [7:0] v);
    // bytes past the end of the no-carry register read as zero
    return (k < 6) ? v : 8'h00;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask
  task automatic op(input rhi_op_type c);
    logic [7:0] s;
    int         n;
    wr(HREG_OP, {5'h00, c});
    n = 0;
    do
    begin
      rd(HREG_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 400);
    if (s[0] !== 1'b0)
    begin
      failures++;
      end_sim();
    end
  endtask
  task automatic send(input logic [7:0] b);
    wr(HREG_DATA, b);
    op(OP_WRITE);
  endtask
  task automatic get(output logic [7:0] b);
    op(OP_READ);
    rd(HREG_RX, b);
  endtask
  // ----
  // main sequence, parallel then serial
  // ----
  initial
  begin
    logic [7:0] lo, hi, n1, q0, q1, r;
    logic [7:0] d [7];
    int         de;
    int         dc;
    i_rst_b = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_queue_pop = 1'b0;
    failures = 0;
    check_count = 0;
    stop_count = 0;
    cmd_count = 0;
    void'($urandom(41));
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      wr(HREG_CTRL, 8'(m));
      op(OP_ENABLE);
      chk(16'(o_serial_mode), 16'(m));
      chk(16'(o_active), 16'h0001);
      lo = 8'($urandom);
      hi = 8'($urandom);
      q0 = 8'($urandom);
      q1 = 8'($urandom);
      dc = cmd_count;
      op(OP_START);
      send(8'h8F);
      chk(16'(o_cmd_code), 16'h000F);
      send(8'h90);
      chk(16'(cmd_count - dc), 16'h0002);
      send(8'h3D);
      send(lo);
      send(hi);
      send(q0);
      send(q1);
      op(OP_STOP_BURST);
      chk(o_tx_length, {hi, lo});
      chk(16'(o_queue_level), 16'h0002);
      chk(16'(o_queue_head), 16'(q0));
      @(posedge i_clk);
      i_queue_pop <= 1'b1;
      @(posedge i_clk);
      i_queue_pop <= 1'b0;
      @(negedge i_clk);
      chk(16'(o_queue_head), 16'(q1));
      n1 = 8'($urandom);
      de = stop_count;
      // refused queue access last, so a misread data byte stays harmless
      op(OP_START);
      send(8'h1D);
      send(n1);
      send(8'h1F);
      send(8'h00);
      op(OP_STOP_SGL);
      chk(16'(o_queue_level), 16'h0001);
      chk(o_tx_length, {hi, n1});
      chk(16'(stop_count - de), 16'(1 - m));
      op(OP_START);
      send(8'h7D);
      get(r);
      chk(16'(r), 16'(n1));
      get(r);
      chk(16'(r), 16'(hi));
      op(OP_STOP_BURST);
      op(OP_START);
      send(8'h32);
      for (int k = 0; k < 7; k++)
      begin
        d[k] = 8'($urandom);
        send(d[k]);
      end
      op(OP_STOP_BURST);
      op(OP_START);
      send(8'h72);
      for (int k = 0; k < 7; k++)
      begin
        get(r);
        chk(16'(r), 16'(deep_exp(k, d[k])));
      end
      op(OP_STOP_BURST);
      op(OP_START);
      send(8'h74);
      get(r);
      chk(16'(r), 16'h0000);
      op(OP_STOP_BURST);
      op(OP_START);
      send(8'h52);
      get(r);
      chk(16'(r), 16'h0000);
      op(OP_STOP_SGL);
      $display("mode %0d test done", m);
    end
    end_sim();
  end
endmodule
`default_nettype wire
